// ===== hw/dpot_params.svh
/*
 constants of the digital pot register slave: register addresses, access
 control field positions, reset values and timing counts.
 assumes mclk at 50 MHz and a slow external serial master.
*/
// Operation
// - seven-bit wiper register sets tap, 00h ground end, 7Fh supply end
// - wiper resets to 40h, then reloads from stored initial value
// - address 0 is wiper/initial value, 1 reserved, 2 access control
// - access control bit 7 picks volatile wiper (1) or initial value (0)
// - writing the initial value also loads the wiper
// - bit 6 shutdown control defaults 1; normal only if bit and pin high
// - shutdown opens array, grounds wiper; leaving restores previous tap
// - serial interface and registers stay usable during shutdown
// - bit 5 is read-only, high while non-volatile write runs
// - while busy, writes to wiper and access control are ignored
// - device is slave only, using master clock for both directions
// - bytes travel most significant bit first
// - data changes only while clock low; high-clock changes mark start/stop
// - watch for start always; ignore all before start and during power-up
// - stop ends every operation and returns device to standby
// - transmitter releases data after eight bits; receiver acks ninth clock
// - device acks id, address and write data; master acks read data
// - id byte needs device code and strap bits; last bit read/write
// - two straps give the two low address bits, four devices per bus
// - sample on rising clock, drive outgoing bits after falling clock
// - data pin stays released until device must transmit or ack
// - write is start, id, address, one data byte, stop, all acked
// - non-volatile write starts at stop and lasts up to 20 ms
// - read is write preamble, repeated start, read id, acked data bytes
`ifndef DPOT_PARAMS_SVH
`define DPOT_PARAMS_SVH
`define DPOT_ADDR_WIPER 8'h00
`define DPOT_ADDR_ACCESS 8'h02
`define DPOT_BIT_VOL 7
`define DPOT_BIT_SHUTDOWN_N 6
`define DPOT_BIT_BUSY 5
`define DPOT_WIPER_RESET 7'h40
`define DPOT_IVR_RESET 8'h40
`define DPOT_VOL_RESET 1'b0
`define DPOT_SHUTDOWN_N_RESET 1'b1
`define DPOT_CODE_W 5
`define DPOT_MCLK_HZ 50000000
`define DPOT_NV_WRITE_MS 20
`define DPOT_NV_WRITE_CYC ((`DPOT_MCLK_HZ / 1000) * `DPOT_NV_WRITE_MS)
`define DPOT_PUP_CYC 16
`endif

// ===== hw/dpot_pkg.sv
/*
 types of the digital pot register slave.
 assumes dpot_params.svh is on the include path.
*/
package dpot_pkg;
    typedef enum logic [2:0] {
        DP_IDLE, DP_ID, DP_ADDR, DP_WDATA, DP_RDATA, DP_ACK, DP_MACK
    } dpot_state_t;
endpackage

// ===== hw/dpot_sync.sv
/*
 three-stage synchroniser with agreement filter for one pin.
 assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module dpot_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic s1, s2, s3;
    logic next_level;
    always_comb begin
        // only stages two and three decide; stage one is metastable guard
        next_level = (s2 == s3) ? s3 : level;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            level <= 1'b1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule // dpot_sync
`default_nettype wire

// ===== hw/dpot_slave.sv
/*
 digital pot core: serial bus slave, wiper, initial value and access
 control registers, shutdown and self-timed non-volatile write.
 assumes open-drain scl/sda with external pull-ups, straps stable.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dpot_params.svh"
module dpot_slave
    import dpot_pkg::*;
#(
    parameter int NV_WRITE_CYC = `DPOT_NV_WRITE_CYC,
    parameter logic [4:0] DEV_CODE = 5'h0B // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    input wire logic shutdown_n,
    output logic [6:0] tap,
    output logic array_open,
    output logic wiper_grounded,
    output logic nv_write_busy
);
    logic scl, sda, scl_d, sda_d;
    logic shutdown_n_pin;
    logic strap_hi, strap_lo;
    // straps are pins, so they pass the same filter
    dpot_sync u_sth (.mclk(mclk), .rst(rst), .pin(addr_strap_hi),
        .level(strap_hi));
    dpot_sync u_stl (.mclk(mclk), .rst(rst), .pin(addr_strap_lo),
        .level(strap_lo));
    dpot_sync u_scl (.mclk(mclk), .rst(rst), .pin(scl_in), .level(scl));
    dpot_sync u_sda (.mclk(mclk), .rst(rst), .pin(sda_in), .level(sda));
    dpot_sync u_shd (.mclk(mclk), .rst(rst), .pin(shutdown_n),
        .level(shutdown_n_pin));

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl & ~scl_d;
    assign scl_fall = ~scl & scl_d;
    assign start_c = scl & scl_d & sda_d & ~sda;
    assign stop_c = scl & scl_d & ~sda_d & sda;

    dpot_state_t state, next_state, ret_state, next_ret_state;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] regaddr, next_regaddr;
    logic [7:0] wiper, next_wiper;
    logic [7:0] initial_wiper_value, next_ivr;
    logic volatile_select, next_vol, shutdown_n_bit, next_shutdown_n_bit;
    logic busy, next_busy;
    logic nv_pend, next_nv_pend;
    logic [20:0] nv_cnt, next_nv_cnt;
    logic [4:0] pup_cnt, next_pup_cnt;
    logic pup_done, next_pup_done;
    logic oe, next_oe;
    logic do_ack, next_do_ack;
    logic [7:0] rd_byte;

    always_comb begin
        unique case (regaddr)
            `DPOT_ADDR_WIPER: rd_byte = volatile_select ? wiper : initial_wiper_value;
            // busy read back; low bits read zero
            `DPOT_ADDR_ACCESS: rd_byte = {volatile_select, shutdown_n_bit, busy, 5'h00};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;
        next_ret_state = ret_state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_regaddr = regaddr;
        next_wiper = wiper;
        next_ivr = initial_wiper_value;
        next_vol = volatile_select;
        next_shutdown_n_bit = shutdown_n_bit;
        next_busy = busy;
        next_nv_pend = nv_pend;
        next_nv_cnt = nv_cnt;
        next_pup_cnt = pup_cnt;
        next_pup_done = pup_done;
        next_oe = oe;
        next_do_ack = do_ack;
        // power-up window then recall initial value
        if (!pup_done) begin
            next_pup_cnt = pup_cnt + 5'h01;
            if (pup_cnt == 5'(`DPOT_PUP_CYC)) begin
                next_pup_done = 1'b1;
                next_wiper = initial_wiper_value;
            end
        end
        // busy counts down the self-timed write
        if (busy) begin
            if (nv_cnt == 21'h000000) begin
                next_busy = 1'b0;
            end else begin
                next_nv_cnt = nv_cnt - 21'h000001;
            end
        end
        if (!pup_done) begin
            next_state = DP_IDLE;
        end else if (start_c) begin
            next_state = DP_ID;
            next_bitcnt = 4'h0;
            next_oe = 1'b0;
        end else if (stop_c) begin
            next_state = DP_IDLE;
            next_oe = 1'b0;
            if (nv_pend) begin
                next_nv_pend = 1'b0;
                next_busy = 1'b1;
                next_nv_cnt = 21'(NV_WRITE_CYC - 1);
            end
        end else begin
            unique case (state)
                DP_IDLE: begin
                    next_oe = 1'b0;
                end
                DP_ID, DP_ADDR, DP_WDATA: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8) begin
                        next_bitcnt = 4'h0;
                        next_do_ack = 1'b1;
                        next_ret_state = state;
                        if (state == DP_ID) begin
                            if (shreg[7:3] == DEV_CODE &&
                                shreg[2:1] == {strap_hi, strap_lo})
                                next_ret_state = shreg[0] ? DP_RDATA : DP_ADDR;
                            else
                                next_do_ack = 1'b0;
                        end else if (state == DP_ADDR) begin
                            next_regaddr = shreg;
                            next_ret_state = DP_WDATA;
                        end else begin
                            // one data byte, then wait for stop
                            next_ret_state = DP_IDLE;
                            if (!busy && regaddr == `DPOT_ADDR_WIPER) begin
                                if (volatile_select) begin
                                    next_wiper = shreg;
                                end else begin
                                    next_ivr = shreg;
                                    next_wiper = shreg;
                                    next_nv_pend = 1'b1;
                                end
                            end else if (!busy &&
                                regaddr == `DPOT_ADDR_ACCESS) begin
                                next_vol = shreg[`DPOT_BIT_VOL];
                                next_shutdown_n_bit = shreg[`DPOT_BIT_SHUTDOWN_N];
                            end
                        end
                        next_oe = next_do_ack;
                        next_state = next_do_ack ? DP_ACK : DP_IDLE;
                    end
                end
                DP_ACK: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_bitcnt = 4'h0;
                        next_state = ret_state;
                        if (ret_state == DP_RDATA) begin
                            next_shreg = rd_byte;
                            next_oe = ~rd_byte[7];
                        end
                    end
                end
                DP_RDATA: begin
                    if (scl_fall) begin
                        next_bitcnt = bitcnt + 4'h1;
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe = (bitcnt == 4'h7) ? 1'b0 : ~shreg[6];
                        if (bitcnt == 4'h7)
                            next_state = DP_MACK;
                    end
                end
                DP_MACK: begin
                    if (scl_rise) begin
                        next_do_ack = ~sda;
                    end
                    if (scl_fall) begin
                        next_bitcnt = 4'h0;
                        next_shreg = rd_byte;
                        next_oe = do_ack & ~rd_byte[7];
                        next_state = do_ack ? DP_RDATA : DP_IDLE;
                    end
                end
                default: next_state = DP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= DP_IDLE;
            ret_state <= DP_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            regaddr <= 8'h00;
            wiper <= {1'b0, `DPOT_WIPER_RESET};
            initial_wiper_value <= `DPOT_IVR_RESET;
            volatile_select <= `DPOT_VOL_RESET;
            shutdown_n_bit <= `DPOT_SHUTDOWN_N_RESET;
            busy <= 1'b0;
            nv_pend <= 1'b0;
            nv_cnt <= 21'h000000;
            pup_cnt <= 5'h00;
            pup_done <= 1'b0;
            oe <= 1'b0;
            do_ack <= 1'b0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            state <= next_state;
            ret_state <= next_ret_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            regaddr <= next_regaddr;
            wiper <= next_wiper;
            initial_wiper_value <= next_ivr;
            volatile_select <= next_vol;
            shutdown_n_bit <= next_shutdown_n_bit;
            busy <= next_busy;
            nv_pend <= next_nv_pend;
            nv_cnt <= next_nv_cnt;
            pup_cnt <= next_pup_cnt;
            pup_done <= next_pup_done;
            oe <= next_oe;
            do_ack <= next_do_ack;
        end
    end

    // open-drain, never drives high; moves on scl low
    assign sda_out = 1'b0;
    assign sda_oe = oe;
    assign nv_write_busy = busy;
    // pin anded with control bit; wiper kept, tap grounded
    assign array_open = ~(shutdown_n_bit & shutdown_n_pin);
    assign wiper_grounded = array_open;
    // tap from seven-bit wiper; bus runs in shutdown
    assign tap = array_open ? 7'h00 : wiper[6:0];

    busy_rise_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(busy) |-> $past(stop_c)) else $error("busy without stop");
    busy_blocks_write_a: assert property (@(posedge mclk) disable iff (rst)
        busy && $past(busy) |-> $stable(volatile_select) && $stable(shutdown_n_bit))
        else $error("access control written while busy");
    shutdown_tap_a: assert property (@(posedge mclk) disable iff (rst)
        (!shutdown_n_bit || !shutdown_n_pin) |-> tap == 7'h00 && array_open)
        else $error("tap not grounded in shutdown");
    normal_tap_a: assert property (@(posedge mclk) disable iff (rst)
        shutdown_n_bit && shutdown_n_pin |-> tap == wiper[6:0])
        else $error("tap differs from wiper");
    pin_release_a: assert property (@(posedge mclk) disable iff (rst)
        state == DP_IDLE && $past(state) == DP_IDLE |-> !sda_oe)
        else $error("data pin driven in standby");
    stop_idle_a: assert property (@(posedge mclk) disable iff (rst)
        stop_c && pup_done |=> state == DP_IDLE && !sda_oe)
        else $error("stop did not return to standby");
    pup_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        !pup_done |=> state == DP_IDLE)
        else $error("bus activity during power-up");
    sda_change_a: assert property (@(posedge mclk) disable iff (rst)
        $changed(sda_oe) |-> !scl)
        else $error("data pin changed with clock high");
endmodule // dpot_slave
`default_nettype wire

// ===== test/dpot_master.sv
/*
 serial bus master model that drives the digital pot from the far side.
 assumes the bench resolves the open-drain sda line with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module dpot_master (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one quarter of a 160 ns bit; clock stands high between frames
    task automatic q(input int n);
        repeat (2 * n) @(posedge mclk);
    endtask
    // data moves only while scl low
    // long low phase: the slave lets go of its ack about five mclk late
    task automatic bit_io(input logic b, output logic s);
        scl <= 1'b0;
        q(1);
        sda_pull <= ~b;
        q(2);
        scl <= 1'b1;
        q(1);
        s = sda_line;
    endtask
    // also a repeated start when called inside a frame
    task automatic start();
        scl <= 1'b0;
        q(1);
        sda_pull <= 1'b0;
        q(2);
        scl <= 1'b1;
        q(1);
        sda_pull <= 1'b1;
        q(1);
    endtask
    task automatic stop();
        scl <= 1'b0;
        q(1);
        sda_pull <= 1'b1;
        q(1);
        scl <= 1'b1;
        q(1);
        sda_pull <= 1'b0;
        q(3);
    endtask
    // msb first, then release for the ack bit
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, ack);
    endtask
    // master acks all but the last byte it reads
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~mack, s);
    endtask
endmodule // dpot_master
`default_nettype wire

// ===== test/test_digipot_i2c_register_slave.sv
/*
 self-checking bench of the digital pot register slave.
 assumes dpot_master as the bus master and a pulled-up sda line.
*/
`timescale 1ns/100ps
`default_nettype none
module test_digipot_i2c_register_slave;
    localparam int NV_CYC = 2000;
    localparam logic [4:0] CODE = 5'h13; // arbitrary value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic shutdown_n = 1'b1;
    logic strap_hi = 1'b0;
    logic strap_lo = 1'b1;
    wire logic scl, sda_pull, sda_line;
    logic sda_out, sda_oe, busy, arr_open, wgnd, k;
    logic [6:0] tap;
    logic [7:0] exp_q[$], got_q[$], v1, v2;
    logic [6:0] d, w;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 32'h32cd6d6c;
    int i;
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
    initial begin
        forever #10 mclk = ~mclk;
    end
    dpot_master u_m (.mclk(mclk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));
    dpot_slave #(.NV_WRITE_CYC(NV_CYC), .DEV_CODE(CODE)) u_dut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(strap_hi),
        .addr_strap_lo(strap_lo), .shutdown_n(shutdown_n), .tap(tap),
        .array_open(arr_open), .wiper_grounded(wgnd),
        .nv_write_busy(busy));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [7:0] id(input logic rw);
        return {CODE, strap_hi, strap_lo, rw};
    endfunction
    task automatic hdr(input logic [7:0] a);
        u_m.start();
        u_m.wbyte(id(1'b0), k);
        chk(8'h00, {7'h00, k});
        u_m.wbyte(a, k);
        chk(8'h00, {7'h00, k});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        hdr(a);
        u_m.wbyte(x, k);
        chk(8'h00, {7'h00, k});
        u_m.stop();
        tick(8);
    endtask
    // read frame, two bytes from one address
    task automatic rdv(input logic [7:0] a);
        hdr(a);
        u_m.start();
        u_m.wbyte(id(1'b1), k);
        chk(8'h00, {7'h00, k});
        u_m.rbyte(1'b1, v1);
        u_m.rbyte(1'b0, v2);
        u_m.stop();
        tick(8);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdv(a);
        chk(e, v1);
        chk(e, v2);
    endtask
    task automatic see_tap(input logic [6:0] t, input logic s);
        chk({1'b0, t}, {1'b0, tap});
        chk({7'h00, s}, {7'h00, arr_open});
        chk({7'h00, s}, {7'h00, wgnd});
    endtask
    always @(posedge mclk) begin
        if (got_q.size() > 0) begin
            n_compared++;
            if (got_q[0] !== exp_q[0]) begin
                mismatches++;
                $display("wrong value at %0t: want %h got %h", $time,
                    exp_q[0], got_q[0]);
            end
            void'(got_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    initial begin
        tick(3);
        rst <= 1'b0;
        tick(40);
        see_tap(7'h40, 1'b0);
        chk(8'h00, {7'h00, sda_oe});
        // unknown device code, then a foreign strap value
        for (i = 0; i < 2; i++) begin
            u_m.start();
            u_m.wbyte(i == 0 ? {~CODE, strap_hi, strap_lo, 1'b0} :
                {CODE, ~strap_hi, strap_lo, 1'b0}, k);
            chk(8'h01, {7'h00, k});
            u_m.stop();
        end
        for (i = 0; i < 4; i++) begin
            {strap_hi, strap_lo} <= 2'(i);
            tick(2);
            rd(8'h02, 8'h40);
        end
        d = 7'($random(seed));
        wr(8'h00, {1'b0, d});
        see_tap(d, 1'b0);
        for (i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
        chk(8'h01, {7'h00, busy});
        rd(8'h02, 8'h60);
        wr(8'h02, 8'hC0);
        chk(8'h01, {7'h00, busy});
        // poll the busy flag as a host would, with a bound
        for (i = 0; i < 8; i++) begin
            rdv(8'h02);
            if (v1[5] === 1'b0) break;
        end
        if (i == 8) begin
            mismatches++;
            results();
        end
        chk(8'h40, v1);
        rd(8'h00, {1'b0, d});
        wr(8'h02, 8'hC0);
        for (i = 0; i < 3; i++) begin
            w = i == 0 ? 7'h00 : i == 1 ? 7'h7F : 7'($random(seed));
            wr(8'h00, {1'b0, w});
            see_tap(w, 1'b0);
            chk(8'h00, {7'h00, busy});
            rd(8'h00, {1'b0, w});
        end
        wr(8'h02, 8'h40);
        rd(8'h00, {1'b0, d});
        wr(8'h01, 8'h55);
        rd(8'h01, 8'h00);
        shutdown_n <= 1'b0;
        tick(10);
        see_tap(7'h00, 1'b1);
        shutdown_n <= 1'b1;
        tick(10);
        see_tap(w, 1'b0);
        wr(8'h02, 8'h80);
        see_tap(7'h00, 1'b1);
        wr(8'h00, 8'h11);
        rd(8'h00, 8'h11);
        wr(8'h02, 8'hC0);
        see_tap(7'h11, 1'b0);
        tick(20);
        results();
    end
endmodule // test_digipot_i2c_register_slave
`default_nettype wire
